/* File: afs_params.svh */
`ifndef AFS_PARAMS_SVH
`define AFS_PARAMS_SVH

// register offsets
`define AFS_OFS_LIVE_TR 8'h47
`define AFS_OFS_LIVE_TB 8'h48
`define AFS_OFS_LT_PROT 8'h49
`define AFS_OFS_LT_DIAG 8'h4A
`define AFS_OFS_LT_CS 8'h4B
`define AFS_OFS_LT_TR 8'h4F
`define AFS_OFS_LT_TB 8'h50
`define AFS_OFS_LT_CET 8'h51
`define AFS_OFS_BAT_HI 8'h52
`define AFS_OFS_BAT_LO 8'h53
`define AFS_OFS_MASK0 8'h3B
`define AFS_OFS_MASK1 8'h3C
`define AFS_OFS_MASK4 8'h3D
`define AFS_OFS_MASK2 8'h40
`define AFS_OFS_MASK3 8'h41
`define AFS_OFS_CFG 8'h5C

// reset values
`define AFS_RST_MASK0 8'hFC
`define AFS_RST_MASK1 8'hBE
`define AFS_RST_MASK4 8'hDF
`define AFS_RST_MASK2 8'hF6
`define AFS_RST_MASK3 8'h00
`define AFS_RST_SEL 2'h1

// field positions
`define AFS_CFG_CLR 2
`define AFS_DIAG_CRC 6
`define AFS_DIAG_DONE 5
`define AFS_DIAG_CODE 3
`define AFS_CS_PLL 7
`define AFS_CS_BATUV 5
`define AFS_PROT_CLKERR 2

// timing
`define AFS_CLK_HZ 10000000
`define AFS_PULSE_MS 2
`define AFS_PERIOD_MS 4

`endif

/* File: afs_pkg.sv */
package afs_pkg;

    // register port request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } afs_regreq_t;

    // live conditions from the device
    typedef struct packed {
        logic [7:0] temp_reg;
        logic [7:0] thermal_bop;
        logic [7:0] protect;
        logic otp_crc;
        logic pll_err;
        logic bat_uv;
    } afs_live_t;

    // load diagnostic result
    typedef struct packed {
        logic done;
        logic [1:0] code;
    } afs_diag_t;

    // port clock error kind, 1 = detected
    typedef struct packed {
        logic invalid_ratio;
        logic rate_changed;
        logic ratio_changed;
    } afs_clkerr_t;

    // interrupt pulse generator
    typedef enum logic [1:0] {
        AFS_IDLE,
        AFS_HIGH,
        AFS_WAIT
    } afs_pulse_state_t;

endpackage

/* File: afs_status_flags.sv */
// What this block does
// - Bits 7..4 of the first live register show die temperature over 105C, 115C, 125C, 135C.
// - Bits 3..0 of that register show regulator under/overvoltage, overload, supply undervolt.
// - A second live register shows thermal thresholds 2 and 1, supply diff, brownout and levels.
// - A latched register holds brownout mute/hold, limiter, port clock, overcurrent, overtemp.
// - A port clock error also records its kind in a latched type register.
// - Checksum error latches in bit 6 and diagnostic completion in bit 5 of the diag register.
// - Bits 4..3 of the diag register give the load result: normal, open, short, reserved.
// - A register latches a PLL error in bit 7 and battery undervolt in bit 5, other bits zero.
// - Latched copies of temperature and regulator events use the live register layout.
// - Latched copies of thermal, supply diff and brownout events use the live layout.
// - The type register marks invalid ratio in bit 2, rate change in 1, ratio change in 0.
// - The rate change type bit reads 0 when detected and 1 when not.
// - The 12-bit battery code reads as bits 11..4 high and 3..0 in the low upper nibble.
// - Writing 1 to the clear bit empties all latched registers except what an event in the clearing cycle sets, and the bit returns to 0.
// - The interrupt pin follows live, latched, one pulse per event or repeated pulses.
// - A mask bit of 1 keeps that event off the interrupt pin, except the checksum error, which ignores its mask bit.
`timescale 1ns/1ps
`default_nettype none
`include "afs_params.svh"

module afs_status_flags #(
    parameter int unsigned PULSE_CYC = `AFS_PULSE_MS * (`AFS_CLK_HZ / 1000),
    parameter int unsigned PERIOD_CYC = `AFS_PERIOD_MS * (`AFS_CLK_HZ / 1000)
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register port
    input wire afs_pkg::afs_regreq_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // device conditions
    input wire afs_pkg::afs_live_t live_in,
    input wire afs_pkg::afs_diag_t diag_in,
    input wire afs_pkg::afs_clkerr_t clkerr_in,
    input wire logic [11:0] bat_code_in,
    input wire logic bat_code_valid,
    // interrupt pin, active low
    output logic irq_n
);
    import afs_pkg::*;

    // sticky update, set wins over clear
    function automatic logic [7:0] f_stick(
        input logic [7:0] old,
        input logic [7:0] set,
        input logic clr
    );
        f_stick = (clr ? 8'h00 : old) | set;
    endfunction

    // any unmasked bit
    function automatic logic f_hit(input logic [7:0] v, input logic [7:0] m);
        f_hit = |(v & ~m);
    endfunction

    logic [7:0] lt_prot_reg, lt_prot_next;
    logic [7:0] lt_tr_reg, lt_tr_next;
    logic [7:0] lt_tb_reg, lt_tb_next;
    logic [7:0] lt_diag_reg, lt_diag_next;
    logic [7:0] lt_cs_reg, lt_cs_next;
    logic [2:0] cet_reg, cet_next;
    logic [11:0] bat_reg;
    logic [7:0] mask0_reg, mask1_reg, mask2_reg, mask3_reg, mask4_reg;
    logic [1:0] sel_reg;
    logic clr_reg;
    logic [7:0] rd_mux;
    logic irq_n_reg;
    afs_pulse_state_t st_reg, st_next;
    logic [15:0] cnt_reg, cnt_next;
    logic live_hit_d_reg;

    // write decode
    wire wr_cfg = reg_req.wr && reg_req.addr == `AFS_OFS_CFG;
    wire wr_m0 = reg_req.wr && reg_req.addr == `AFS_OFS_MASK0;
    wire wr_m1 = reg_req.wr && reg_req.addr == `AFS_OFS_MASK1;
    wire wr_m2 = reg_req.wr && reg_req.addr == `AFS_OFS_MASK2;
    wire wr_m3 = reg_req.wr && reg_req.addr == `AFS_OFS_MASK3;
    wire wr_m4 = reg_req.wr && reg_req.addr == `AFS_OFS_MASK4;

    // live vectors in latched layout
    wire [7:0] diag_live = {1'b0, live_in.otp_crc, diag_in.done,
                            (diag_in.done ? diag_in.code : 2'b00), 3'b000};
    wire [7:0] cs_live = {live_in.pll_err, 1'b0, live_in.bat_uv, 5'h00};
    wire clk_err = live_in.protect[`AFS_PROT_CLKERR];

    assign lt_prot_next = f_stick(lt_prot_reg, live_in.protect, clr_reg);
    assign lt_tr_next = f_stick(lt_tr_reg, live_in.temp_reg, clr_reg);
    assign lt_tb_next = f_stick(lt_tb_reg, live_in.thermal_bop, clr_reg);
    assign lt_diag_next = f_stick(lt_diag_reg, diag_live, clr_reg);
    assign lt_cs_next = f_stick(lt_cs_reg, cs_live, clr_reg);

    assign cet_next = clk_err ? {clkerr_in.invalid_ratio, ~clkerr_in.rate_changed,
                                 clkerr_in.ratio_changed}
                    : (clr_reg ? 3'b000 : cet_reg);

    // latched flag registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            lt_prot_reg <= 8'h00;
            lt_tr_reg <= 8'h00;
            lt_tb_reg <= 8'h00;
            lt_diag_reg <= 8'h00;
            lt_cs_reg <= 8'h00;
            cet_reg <= 3'b000;
        end else begin
            lt_prot_reg <= lt_prot_next;
            lt_tr_reg <= lt_tr_next;
            lt_tb_reg <= lt_tb_next;
            lt_diag_reg <= lt_diag_next;
            lt_cs_reg <= lt_cs_next;
            cet_reg <= cet_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            bat_reg <= 12'h000;
        end else if (bat_code_valid) begin
            bat_reg <= bat_code_in;
        end
    end

    // mask and config registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mask0_reg <= `AFS_RST_MASK0;
            mask1_reg <= `AFS_RST_MASK1;
            mask2_reg <= `AFS_RST_MASK2;
            mask3_reg <= `AFS_RST_MASK3;
            mask4_reg <= `AFS_RST_MASK4;
            sel_reg <= `AFS_RST_SEL;
        end else begin
            if (wr_m0) mask0_reg <= reg_req.wdata;
            if (wr_m1) mask1_reg <= reg_req.wdata;
            if (wr_m2) mask2_reg <= reg_req.wdata;
            if (wr_m3) mask3_reg <= reg_req.wdata;
            if (wr_m4) mask4_reg <= reg_req.wdata;
            if (wr_cfg) sel_reg <= reg_req.wdata[1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            clr_reg <= 1'b0;
        end else begin
            clr_reg <= wr_cfg && reg_req.wdata[`AFS_CFG_CLR];
        end
    end

    // read select
    always_comb begin
        rd_mux = 8'h00;
        unique case (reg_req.addr)
            `AFS_OFS_LIVE_TR: rd_mux = live_in.temp_reg;
            `AFS_OFS_LIVE_TB: rd_mux = live_in.thermal_bop;
            `AFS_OFS_LT_PROT: rd_mux = lt_prot_reg;
            `AFS_OFS_LT_DIAG: rd_mux = lt_diag_reg;
            `AFS_OFS_LT_CS: rd_mux = lt_cs_reg;
            `AFS_OFS_LT_TR: rd_mux = lt_tr_reg;
            `AFS_OFS_LT_TB: rd_mux = lt_tb_reg;
            `AFS_OFS_LT_CET: rd_mux = {5'h00, cet_reg};
            `AFS_OFS_BAT_HI: rd_mux = bat_reg[11:4];
            `AFS_OFS_BAT_LO: rd_mux = {bat_reg[3:0], 4'h0};
            `AFS_OFS_MASK0: rd_mux = mask0_reg;
            `AFS_OFS_MASK1: rd_mux = mask1_reg;
            `AFS_OFS_MASK2: rd_mux = mask2_reg;
            `AFS_OFS_MASK3: rd_mux = mask3_reg;
            `AFS_OFS_MASK4: rd_mux = mask4_reg;
            `AFS_OFS_CFG: rd_mux = {5'h00, clr_reg, sel_reg};
            default: rd_mux = 8'h00;
        endcase
    end

    // read data register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd) reg_rdata <= rd_mux;
        end
    end

    wire live_hit = f_hit(live_in.temp_reg, mask2_reg)
                  | f_hit(live_in.thermal_bop, mask3_reg)
                  | f_hit(live_in.protect, mask0_reg)
                  | f_hit(diag_live & 8'h38, mask1_reg)
                  | f_hit(cs_live, mask4_reg)
                  | live_in.otp_crc;
    wire lat_hit = f_hit(lt_tr_reg, mask2_reg)
                 | f_hit(lt_tb_reg, mask3_reg)
                 | f_hit(lt_prot_reg, mask0_reg)
                 | f_hit(lt_diag_reg & 8'h38, mask1_reg)
                 | f_hit(lt_cs_reg, mask4_reg)
                 | lt_diag_reg[`AFS_DIAG_CRC];

    wire live_rise = live_hit && !live_hit_d_reg;
    wire trig = (sel_reg == 2'b10 && live_rise) || (sel_reg == 2'b11 && lat_hit);
    wire pulse_end = cnt_reg == 16'(PULSE_CYC - 1);
    wire period_end = cnt_reg == 16'(PERIOD_CYC - 1);

    // pulse generator next state
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg + 16'h0001;
        unique case (st_reg)
            AFS_IDLE: begin
                cnt_next = 16'h0000;
                if (trig) st_next = AFS_HIGH;
            end
            AFS_HIGH: begin
                if (pulse_end) st_next = (sel_reg == 2'b11) ? AFS_WAIT : AFS_IDLE;
                if (pulse_end && sel_reg != 2'b11) cnt_next = 16'h0000;
            end
            AFS_WAIT: begin
                if (period_end) begin
                    st_next = (sel_reg == 2'b11 && lat_hit) ? AFS_HIGH : AFS_IDLE;
                    cnt_next = 16'h0000;
                end
            end
            default: begin
                st_next = AFS_IDLE;
                cnt_next = 16'h0000;
            end
        endcase
    end

    wire irq_on = (sel_reg == 2'b00) ? live_hit
                : (sel_reg == 2'b01) ? lat_hit
                : (st_reg == AFS_HIGH);

    // pulse state and pin register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            st_reg <= AFS_IDLE;
            cnt_reg <= 16'h0000;
            live_hit_d_reg <= 1'b0;
            irq_n_reg <= 1'b1;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            live_hit_d_reg <= live_hit;
            irq_n_reg <= ~irq_on;
        end
    end

    assign irq_n = irq_n_reg;

    // live temperature readback
    property p_live_temp;
        @(posedge clk_sys) disable iff (!rstn)
        reg_req.rd && reg_req.addr == `AFS_OFS_LIVE_TR
        |=> reg_rdata == $past(live_in.temp_reg) && reg_rvalid;
    endproperty
    a_live_temp: assert property (p_live_temp) else $error("live temp readback wrong");

    // live thermal readback
    property p_live_tb;
        @(posedge clk_sys) disable iff (!rstn)
        reg_req.rd && reg_req.addr == `AFS_OFS_LIVE_TB
        |=> reg_rdata == $past(live_in.thermal_bop);
    endproperty
    a_live_tb: assert property (p_live_tb) else $error("live thermal readback wrong");

    // latch holds after live drops
    property p_sticky;
        @(posedge clk_sys) disable iff (!rstn)
        live_in.protect[0] ##1 !clr_reg [*2] |-> lt_prot_reg[0];
    endproperty
    a_sticky: assert property (p_sticky) else $error("latched bit not held");

    // clear empties latch
    property p_clear;
        @(posedge clk_sys) disable iff (!rstn)
        clr_reg && live_in.temp_reg == 8'h00 |=> lt_tr_reg == 8'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not empty latch");

    // clear bit self clears
    property p_clr_self;
        @(posedge clk_sys) disable iff (!rstn)
        $rose(clr_reg) && !wr_cfg |=> !clr_reg;
    endproperty
    a_clr_self: assert property (p_clr_self) else $error("clear bit stuck");

    // inverted rate change bit
    property p_rate_inv;
        @(posedge clk_sys) disable iff (!rstn)
        clk_err |=> cet_reg[1] == !$past(clkerr_in.rate_changed);
    endproperty
    a_rate_inv: assert property (p_rate_inv) else $error("rate type encoding wrong");

    // battery capture
    property p_bat;
        @(posedge clk_sys) disable iff (!rstn)
        bat_code_valid |=> bat_reg == $past(bat_code_in);
    endproperty
    a_bat: assert property (p_bat) else $error("battery code not captured");

    // reserved bits of pll register
    property p_cs_zero;
        @(posedge clk_sys) disable iff (!rstn)
        reg_req.rd && reg_req.addr == `AFS_OFS_LT_CS |=> (reg_rdata & 8'h5F) == 8'h00;
    endproperty
    a_cs_zero: assert property (p_cs_zero) else $error("reserved bits not zero");

    // live mode drives pin
    property p_live_pin;
        @(posedge clk_sys) disable iff (!rstn)
        sel_reg == 2'b00 && live_hit |=> !irq_n;
    endproperty
    a_live_pin: assert property (p_live_pin) else $error("live mode pin idle");

    // pulse length bounded
    property p_pulse_len;
        @(posedge clk_sys) disable iff (!rstn)
        st_reg == AFS_HIGH |-> cnt_reg < 16'(PULSE_CYC);
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("pulse too long");

    // fully masked event stays off
    property p_mask;
        @(posedge clk_sys) disable iff (!rstn)
        mask0_reg[0] && live_in.protect == 8'h01 && live_in.temp_reg == 8'h00
        && live_in.thermal_bop == 8'h00 && cs_live == 8'h00 && diag_live == 8'h00 |-> !live_hit;
    endproperty
    a_mask: assert property (p_mask) else $error("masked event reached pin");

endmodule

`default_nettype wire

/* File: afs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module afs_host_model (
    // clock
    input wire logic clk_sys,
    // register port
    output var afs_pkg::afs_regreq_t reg_req
);
    import afs_pkg::*;

    // bus idle from time zero
    initial begin
        reg_req = '0;
    end

    // one read cycle, address scrambled once released
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        #1;
        reg_req.addr = a;
        reg_req.rd = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_req.rd = 1'b0;
        reg_req.addr = ~a;
    endtask

    // one write cycle, data scrambled once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_req.addr = a;
        reg_req.wdata = d;
        reg_req.wr = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_req.wr = 1'b0;
        reg_req.addr = ~a;
        reg_req.wdata = ~d;
    endtask
endmodule

`default_nettype wire

/* File: afs_status_flags_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "afs_params.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module afs_status_flags_tb_top;
    import afs_pkg::*;

    logic clk_sys;
    logic rstn;
    afs_regreq_t reg_req;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    afs_live_t live_in;
    afs_diag_t diag_in;
    afs_clkerr_t clkerr_in;
    logic [11:0] bat_code_in;
    logic bat_code_valid;
    logic irq_n;
    int n_fail;
    int samples_checked;
    int seed;
    int falls;
    int lows;
    logic [7:0] exp_q[$];
    logic [7:0] acc_a, acc_b, acc_c, v_m;
    logic [7:0] addrs[12] = '{8'h47, 8'h48, 8'h49, 8'h4A, 8'h4B, 8'h4F, 8'h50, 8'h51,
        8'h52, 8'h53, 8'h00, 8'hFF};
    logic [2:0] k;
    logic [1:0] c;
    logic [11:0] bc;

    afs_status_flags #(.PULSE_CYC(8), .PERIOD_CYC(16)) dut_u (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .reg_req(reg_req),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .live_in(live_in),
        .diag_in(diag_in),
        .clkerr_in(clkerr_in),
        .bat_code_in(bat_code_in),
        .bat_code_valid(bat_code_valid),
        .irq_n(irq_n)
    );

    afs_host_model host_u (
        .clk_sys(clk_sys),
        .reg_req(reg_req)
    );

    // clock generator
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // read monitor pops the oldest expected value
    always @(posedge clk_sys) begin
        if (reg_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("BAD t=%0t got=%h exp=%h", $time, reg_rdata, 8'h00);
            end else begin
                v_m = exp_q.pop_front();
                `CHK(reg_rdata, v_m)
            end
        end
    end

    task automatic end_sim;
        // reads still owed count as lost answers
        if (exp_q.size() != 0) n_fail++;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.rd(a);
    endtask

    // clear latches, keep the given irq select
    task automatic clr_lt(input logic [1:0] sel);
        host_u.wr(8'h5C, {6'h01, sel});
        cyc(2);
    endtask

    // count falling edges and low cycles of the irq pin
    task automatic watch_irq(input int n);
        logic prev;
        prev = irq_n;
        falls = 0;
        lows = 0;
        repeat (n) begin
            cyc(1);
            if (irq_n === 1'b0) lows++;
            if (prev === 1'b1 && irq_n === 1'b0) falls++;
            prev = irq_n;
        end
    endtask

    // watchdog
    initial begin
        #3000000;
        n_fail++;
        end_sim();
    end

    // main sequence
    initial begin
        rstn = 1'b0;
        seed = 35707;
        live_in = '0;
        diag_in = '0;
        clkerr_in = '0;
        bat_code_in = 12'h000;
        bat_code_valid = 1'b0;
        acc_a = 8'h00;
        acc_b = 8'h00;
        acc_c = 8'h00;
        repeat (2) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        // reset values and unmapped reads
        foreach (addrs[i]) rd_exp(addrs[i], 8'h00);
        rd_exp(`AFS_OFS_MASK0, `AFS_RST_MASK0);
        rd_exp(`AFS_OFS_MASK1, `AFS_RST_MASK1);
        rd_exp(`AFS_OFS_MASK2, `AFS_RST_MASK2);
        rd_exp(`AFS_OFS_MASK3, `AFS_RST_MASK3);
        rd_exp(`AFS_OFS_MASK4, `AFS_RST_MASK4);
        rd_exp(`AFS_OFS_CFG, {6'h00, `AFS_RST_SEL});
        `CHK(irq_n, 1'b1)
        // random live flags, accumulated for the sticky copies
        repeat (6) begin
            live_in.temp_reg = 8'($random(seed));
            live_in.thermal_bop = 8'($random(seed));
            live_in.protect = 8'($random(seed));
            acc_a = acc_a | live_in.temp_reg;
            acc_b = acc_b | live_in.thermal_bop;
            acc_c = acc_c | live_in.protect;
            rd_exp(8'h47, live_in.temp_reg);
            rd_exp(8'h48, live_in.thermal_bop);
        end
        live_in = '0;
        cyc(1);
        rd_exp(8'h47, 8'h00);
        rd_exp(8'h4F, acc_a);
        rd_exp(8'h50, acc_b);
        host_u.wr(8'h49, 8'hFF);
        rd_exp(8'h49, acc_c);
        rd_exp(8'h51, acc_c[2] ? 8'h02 : 8'h00);
        clr_lt(2'h1);
        foreach (addrs[i]) if (i >= 2 && i <= 7) rd_exp(addrs[i], 8'h00);
        rd_exp(`AFS_OFS_CFG, 8'h01);
        `CHK(irq_n, 1'b1)
        // every clock error kind combination
        for (int i = 0; i < 8; i++) begin
            k = 3'(i);
            clkerr_in = k;
            live_in.protect = 8'h04;
            cyc(1);
            live_in.protect = 8'h00;
            clkerr_in = ~k;
            rd_exp(8'h51, {5'h00, k[2], ~k[1], k[0]});
            rd_exp(8'h49, 8'h04);
        end
        // load result codes with checksum, pll and battery flags
        for (int i = 0; i < 3; i++) begin
            c = 2'(i);
            clr_lt(2'h1);
            diag_in = {1'b1, c};
            live_in.otp_crc = c[0];
            live_in.pll_err = c[1];
            live_in.bat_uv = ~c[0];
            cyc(1);
            diag_in = '0;
            live_in = '0;
            rd_exp(8'h4A, {1'b0, c[0], 1'b1, c, 3'h0});
            rd_exp(8'h4B, {c[1], 1'b0, ~c[0], 5'h00});
        end
        // battery converter readout
        repeat (3) begin
            bc = 12'($random(seed));
            bat_code_in = bc;
            bat_code_valid = 1'b1;
            cyc(1);
            bat_code_valid = 1'b0;
            bat_code_in = ~bc;
            rd_exp(8'h52, bc[11:4]);
            rd_exp(8'h53, {bc[3:0], 4'h0});
        end
        // latched mode, then masked event
        clr_lt(2'h1);
        `CHK(irq_n, 1'b1)
        live_in.protect = 8'h01;
        cyc(1);
        live_in.protect = 8'h00;
        cyc(1);
        `CHK(irq_n, 1'b0)
        cyc(3);
        `CHK(irq_n, 1'b0)
        host_u.wr(8'h3B, 8'hFD);
        rd_exp(8'h3B, 8'hFD);
        clr_lt(2'h1);
        live_in.protect = 8'h01;
        cyc(1);
        live_in.protect = 8'h00;
        cyc(3);
        `CHK(irq_n, 1'b1)
        rd_exp(8'h49, 8'h01);
        // live mode follows the condition
        host_u.wr(8'h5C, 8'h00);
        live_in.protect = 8'h02;
        cyc(2);
        `CHK(irq_n, 1'b0)
        live_in.protect = 8'h00;
        cyc(2);
        `CHK(irq_n, 1'b1)
        // one pulse per live event
        host_u.wr(8'h5C, 8'h02);
        live_in.protect = 8'h02;
        watch_irq(40);
        `CHK(falls, 1)
        `CHK(lows, 8)
        live_in.protect = 8'h00;
        // repeated pulses while latched hit stays
        host_u.wr(8'h5C, 8'h03);
        watch_irq(40);
        `CHK(falls, 3)
        cyc(3);
        end_sim();
    end
endmodule

`default_nettype wire
